// >>> core/pw_entry_check.sv
// Decoder and fault checks for one 8-byte table entry.
`timescale 1ns/1ps
module pw_entry_check
  import pw_pkg::*;
#(
  parameter bit HAS_CONTIG = 1'b0,
  parameter bit HAS_MTYPE = 1'b0
) (
  // Entry, walk position and access type
  input wire logic [63:0] entry,
  input wire logic [1:0] level,
  input wire pw_acc_type acc,
  // Decode
  output logic bad,
  output logic leaf,
  output logic misaligned,
  output logic need_update,
  output logic [PW_PPN_W-1:0] ppn
);

  logic [PW_PPN_W-1:0] low_mask;

  // Decode fields in the common entry layout.
  assign ppn = entry[PW_E_PPN_HI:PW_E_PPN_LO];
  assign leaf = entry[PW_E_R] | entry[PW_E_X];

  always_comb begin
    bad = 1'b0;
    if (!entry[PW_E_V]) begin
      bad = 1'b1;
    end
    if (!entry[PW_E_R] && entry[PW_E_W]) begin
      bad = 1'b1;
    end
    if (!HAS_CONTIG && entry[PW_E_CONTIG]) begin
      bad = 1'b1;
    end
    if (!HAS_MTYPE && (entry[PW_E_MTYPE_HI:PW_E_MTYPE_LO] != 2'h0)) begin
      bad = 1'b1;
    end
    if (entry[PW_E_RSV_HI:PW_E_RSV_LO] != 7'h00) begin
      bad = 1'b1;
    end
    // Non-leaf entries keep dirty, accessed and user as reserved.
    if (entry[PW_E_V] && !(entry[PW_E_R] | entry[PW_E_X]) &&
        (entry[PW_E_D] | entry[PW_E_A] | entry[PW_E_U])) begin
      bad = 1'b1;
    end
  end

  // Superpage pieces below the leaf level must be zero.
  always_comb begin
    low_mask = '0;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(level)) begin
        low_mask[i*PW_IDX_W +: PW_IDX_W] = 9'h1ff;
      end
    end
  end
  assign misaligned = (ppn & low_mask) != '0;

  assign need_update = !entry[PW_E_A] ||
                       ((acc == PW_ACC_STORE) && !entry[PW_E_D]);

endmodule

// >>> core/pw_pkg.sv
// Package with constants and types for the page walker.
package pw_pkg;

  // Address layout.
  localparam int PW_VA_W = 64;
  localparam int PW_PA_W = 56;
  localparam int PW_OFF_W = 12;
  localparam int PW_PPN_W = 44;
  localparam int PW_IDX_W = 9;
  localparam int PW_SIGN_BIT_39 = 38;
  localparam int PW_SIGN_BIT_48 = 47;

  // Table geometry.
  localparam int PW_LEVELS_39 = 3;
  localparam int PW_LEVELS_48 = 4;
  localparam int PW_ENTRY_SIZE_BYTES = 8;
  localparam int PW_ENTRY_SHIFT = 3;
  localparam int PW_TABLE_ENTRIES = 512;

  // Entry field positions.
  localparam int PW_E_CONTIG = 63;
  localparam int PW_E_MTYPE_HI = 62;
  localparam int PW_E_MTYPE_LO = 61;
  localparam int PW_E_RSV_HI = 60;
  localparam int PW_E_RSV_LO = 54;
  localparam int PW_E_PPN_HI = 53;
  localparam int PW_E_PPN_LO = 10;
  localparam int PW_E_SW_HI = 9;
  localparam int PW_E_SW_LO = 8;
  localparam int PW_E_D = 7;
  localparam int PW_E_A = 6;
  localparam int PW_E_G = 5;
  localparam int PW_E_U = 4;
  localparam int PW_E_X = 3;
  localparam int PW_E_W = 2;
  localparam int PW_E_R = 1;
  localparam int PW_E_V = 0;

  // Translation schemes selected per request.
  typedef enum logic {
    PW_MODE_39 = 1'b0,
    PW_MODE_48 = 1'b1
  } pw_mode_type;

  // Original access types.
  typedef enum logic [1:0] {
    PW_ACC_FETCH = 2'h0,
    PW_ACC_LOAD = 2'h1,
    PW_ACC_STORE = 2'h2
  } pw_acc_type;

endpackage

// >>> core/pw_va_check.sv
// Sign-extension check of a virtual address for both schemes.
`timescale 1ns/1ps
module pw_va_check
  import pw_pkg::*;
(
  // Address and scheme
  input wire logic [PW_VA_W-1:0] va,
  input wire pw_mode_type mode,
  // Result
  output logic va_bad
);

  logic [PW_VA_W-1:0] ext39;
  logic [PW_VA_W-1:0] ext48;

  assign ext39 = {{(PW_VA_W-PW_SIGN_BIT_39-1){va[PW_SIGN_BIT_39]}},
                  va[PW_SIGN_BIT_39:0]};
  assign ext48 = {{(PW_VA_W-PW_SIGN_BIT_48-1){va[PW_SIGN_BIT_48]}},
                  va[PW_SIGN_BIT_48:0]};

  // Upper bits must all copy the top bit of the scheme.
  assign va_bad = (mode == PW_MODE_48) ? (va != ext48)
                                       : (va != ext39);

endmodule

// >>> core/pw_walker.sv
// Page-table walker for the 39-bit and 48-bit paged schemes.
// Summary of operation
// - 39-bit: bits 63..39 must copy bit 38.
// - 39-bit: 27-bit page number, three levels.
// - Tables are 512 aligned 8-byte entries.
// - Walk starts at root page number input.
// - Entry bit 63 set faults.
// - Entry bits 62..61 nonzero fault.
// - Reserved entry bits 60..54 set fault.
// - 39-bit leaves any level; misaligned superpage faults.
// - 39-bit walk uses three levels, 8 bytes.
// - 48-bit support includes 39-bit support.
// - 48-bit: bits 63..48 must copy bit 47.
// - 48-bit: 36-bit page number, four levels.
// - Entry field layout decoded as documented.
// - 48-bit leaves any level; misaligned superpage faults.
// - 48-bit walk uses four levels, 8 bytes.
// - Larger schemes nest; 57-bit not provided here.
// - Invalid, write-only or reserved entry faults.
// - Read/execute means leaf; otherwise descend, else fault.
// - Atomically set accessed/dirty; retry on mismatch.
// - Address from entry pieces plus virtual pieces.
`timescale 1ns/1ps
module pw_walker
  import pw_pkg::*;
#(
  parameter bit HAS_CONTIG = 1'b0,
  parameter bit HAS_MTYPE = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Root table page number from the translation control register
  input wire logic [PW_PPN_W-1:0] root_ppn,
  // Translation request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [PW_VA_W-1:0] req_va,
  input wire pw_mode_type req_mode,
  input wire pw_acc_type req_acc,
  // Translation result
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [PW_PA_W-1:0] rsp_pa,
  output logic rsp_fault,
  output pw_acc_type rsp_acc,
  // Memory request for entry reads and atomic updates
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic [PW_PA_W-1:0] mem_req_addr,
  output logic mem_req_cas,
  output logic [63:0] mem_req_cmp,
  output logic [63:0] mem_req_wdata,
  // Memory response
  input wire logic mem_rsp_valid,
  input wire logic [63:0] mem_rsp_data,
  input wire logic mem_rsp_cas_ok
);

  typedef enum logic [2:0] {
    PW_ST_IDLE = 3'b000,
    PW_ST_READ = 3'b001,
    PW_ST_RWAIT = 3'b010,
    PW_ST_CHECK = 3'b011,
    PW_ST_CAS = 3'b100,
    PW_ST_CWAIT = 3'b101,
    PW_ST_DONE = 3'b110
  } pw_state_type;

  pw_state_type state_q;
  logic [PW_VA_W-1:0] va_q;
  pw_mode_type mode_q;
  pw_acc_type acc_q;
  logic [1:0] level_q;
  logic [PW_PPN_W-1:0] table_q;
  logic [63:0] entry_q;
  logic [PW_PA_W-1:0] pa_q;
  logic fault_q;

  logic va_bad;
  logic e_bad;
  logic e_leaf;
  logic e_misaligned;
  logic e_need_update;
  logic [PW_PPN_W-1:0] e_ppn;
  logic [PW_IDX_W-1:0] vpn_idx;
  logic [PW_PPN_W-1:0] pa_ppn;
  logic [63:0] upd_entry;
  logic [1:0] top_level;

  pw_va_check u_va_check (
    .va(req_va),
    .mode(req_mode),
    .va_bad(va_bad)
  );

  pw_entry_check #(
    .HAS_CONTIG(HAS_CONTIG),
    .HAS_MTYPE(HAS_MTYPE)
  ) u_entry_check (
    .entry(entry_q),
    .level(level_q),
    .acc(acc_q),
    .bad(e_bad),
    .leaf(e_leaf),
    .misaligned(e_misaligned),
    .need_update(e_need_update),
    .ppn(e_ppn)
  );

  // Top level index: two for three levels, three for four.
  assign top_level = (req_mode == PW_MODE_48) ?
                     2'(PW_LEVELS_48 - 1) :
                     2'(PW_LEVELS_39 - 1);

  // Nine-bit index of the current level, taken from the virtual address.
  assign vpn_idx = va_q[PW_OFF_W + level_q*PW_IDX_W +: PW_IDX_W];

  // Keep leaf pieces above the level, virtual pieces below.
  always_comb begin
    pa_ppn = e_ppn;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(level_q)) begin
        pa_ppn[i*PW_IDX_W +: PW_IDX_W] =
          va_q[PW_OFF_W + i*PW_IDX_W +: PW_IDX_W];
      end
    end
  end

  always_comb begin
    upd_entry = entry_q;
    upd_entry[PW_E_A] = 1'b1;
    if (acc_q == PW_ACC_STORE) begin
      upd_entry[PW_E_D] = 1'b1;
    end
  end

  assign req_ready = (state_q == PW_ST_IDLE);
  assign rsp_valid = (state_q == PW_ST_DONE);
  assign rsp_pa = pa_q;
  assign rsp_fault = fault_q;
  assign rsp_acc = acc_q;

  assign mem_req_valid = (state_q == PW_ST_READ) || (state_q == PW_ST_CAS);
  // Entry address: table base plus index times eight, naturally aligned.
  assign mem_req_addr = {table_q, vpn_idx,
                         PW_ENTRY_SHIFT'(0)};
  assign mem_req_cas = (state_q == PW_ST_CAS);
  assign mem_req_cmp = entry_q;
  assign mem_req_wdata = upd_entry;

  // Walk sequencing.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= PW_ST_IDLE;
    end else begin
      unique case (state_q)
        PW_ST_IDLE: begin
          if (req_valid) begin
            state_q <= va_bad ? PW_ST_DONE : PW_ST_READ;
          end
        end
        PW_ST_READ: begin
          if (mem_req_ready) begin
            state_q <= PW_ST_RWAIT;
          end
        end
        PW_ST_RWAIT: begin
          if (mem_rsp_valid) begin
            state_q <= PW_ST_CHECK;
          end
        end
        PW_ST_CHECK: begin
          if (e_bad || (e_leaf && e_misaligned)) begin
            state_q <= PW_ST_DONE;
          end else if (e_leaf) begin
            state_q <= e_need_update ? PW_ST_CAS : PW_ST_DONE;
          end else if (level_q == 2'h0) begin
            state_q <= PW_ST_DONE;
          end else begin
            state_q <= PW_ST_READ;
          end
        end
        PW_ST_CAS: begin
          if (mem_req_ready) begin
            state_q <= PW_ST_CWAIT;
          end
        end
        PW_ST_CWAIT: begin
          if (mem_rsp_valid) begin
            // A failed compare rereads the same entry.
            state_q <= mem_rsp_cas_ok ? PW_ST_DONE
                                      : PW_ST_READ;
          end
        end
        PW_ST_DONE: begin
          if (rsp_ready) begin
            state_q <= PW_ST_IDLE;
          end
        end
        default: begin
          state_q <= PW_ST_IDLE;
        end
      endcase
    end
  end

  // Request capture.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      va_q <= '0;
      mode_q <= PW_MODE_39;
      acc_q <= PW_ACC_FETCH;
    end else if (state_q == PW_ST_IDLE && req_valid) begin
      va_q <= req_va;
      mode_q <= req_mode;
      acc_q <= req_acc;
    end
  end

  // Level and table base.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_q <= 2'h0;
      table_q <= '0;
    end else if (state_q == PW_ST_IDLE && req_valid) begin
      level_q <= top_level;
      table_q <= root_ppn;
    end else if (state_q == PW_ST_CHECK && !e_bad && !e_leaf &&
                 level_q != 2'h0) begin
      level_q <= level_q - 2'h1;
      table_q <= e_ppn;
    end
  end

  // Fetched entry.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      entry_q <= '0;
    end else if (state_q == PW_ST_RWAIT && mem_rsp_valid) begin
      entry_q <= mem_rsp_data;
    end
  end

  // Result address and fault flag.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_q <= '0;
      fault_q <= 1'b0;
    end else if (state_q == PW_ST_IDLE && req_valid) begin
      pa_q <= '0;
      fault_q <= va_bad;
    end else if (state_q == PW_ST_CHECK) begin
      if (e_bad || (e_leaf && e_misaligned) ||
          (!e_leaf && level_q == 2'h0)) begin
        fault_q <= 1'b1;
      end else if (e_leaf) begin
        pa_q <= {pa_ppn, va_q[PW_OFF_W-1:0]};
      end
    end
  end

endmodule

// >>> tb/pw_mem_model.sv
// Memory holding table entries, serving reads and atomic updates.
`timescale 1ns/1ps
module pw_mem_model
  import pw_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Request
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic [PW_PA_W-1:0] mem_req_addr,
  input wire logic mem_req_cas,
  input wire logic [63:0] mem_req_cmp,
  input wire logic [63:0] mem_req_wdata,
  // Response
  output logic mem_rsp_valid,
  output logic [63:0] mem_rsp_data,
  output logic mem_rsp_cas_ok
);
  logic [63:0] mem [logic [PW_PA_W-1:0]];
  bit slow;
  bit fail_cas;
  bit busy;
  bit ok;
  int cnt;
  logic [63:0] rd;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_req_ready <= 1'b0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_data <= '0;
      mem_rsp_cas_ok <= 1'b0;
      busy = 0;
    end else begin
      mem_rsp_valid <= 1'b0;
      mem_rsp_cas_ok <= 1'b0;
      mem_rsp_data <= ~mem_rsp_data;
      if (mem_req_valid && mem_req_ready) begin
        rd = mem.exists(mem_req_addr) ? mem[mem_req_addr] : '0;
        ok = mem_req_cas && rd === mem_req_cmp && !fail_cas;
        if (mem_req_cas)
          fail_cas = 0;
        if (ok)
          mem[mem_req_addr] = mem_req_wdata;
        mem_req_ready <= 1'b0;
        busy = 1;
        cnt = slow ? 4 : 0;
      end else if (busy && cnt > 0) begin
        cnt--;
      end else if (busy) begin
        mem_rsp_valid <= 1'b1;
        mem_rsp_data <= rd;
        mem_rsp_cas_ok <= ok;
        busy = 0;
      end else begin
        mem_req_ready <= mem_req_valid;
      end
    end
  end
endmodule

// >>> tb/pw_walker_checker.sv
// Assertions on the page walker ports.
`timescale 1ns/1ps
module pw_walker_checker
  import pw_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Translation port
  input wire logic [PW_PPN_W-1:0] root_ppn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [PW_VA_W-1:0] req_va,
  input wire pw_mode_type req_mode,
  input wire pw_acc_type req_acc,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [PW_PA_W-1:0] rsp_pa,
  input wire logic rsp_fault,
  input wire pw_acc_type rsp_acc,
  // Memory port
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire logic [PW_PA_W-1:0] mem_req_addr
);
  logic [PW_VA_W-1:0] va_q;
  logic [PW_PPN_W-1:0] root_q;
  pw_mode_type mode_q;
  pw_acc_type acc_q;
  logic first_q;
  wire bad39 = !(&req_va[63:38] || !(|req_va[63:38]));
  wire bad48 = !(&req_va[63:47] || !(|req_va[63:47]));
  wire [8:0] idx = mode_q ? va_q[47:39] : va_q[38:30];
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_q <= 1'b0;
    end else if (req_valid && req_ready) begin
      va_q <= req_va;
      root_q <= root_ppn;
      mode_q <= req_mode;
      acc_q <= req_acc;
      first_q <= 1'b1;
    end else if (mem_req_valid && mem_req_ready) begin
      first_q <= 1'b0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  a_sign_39: assert property (s_take ##0 (!req_mode && bad39)
    |=> rsp_valid && rsp_fault) else $error("no 39-bit sign fault");
  a_sign_48: assert property (s_take ##0 (req_mode && bad48)
    |=> rsp_valid && rsp_fault) else $error("no 48-bit sign fault");
  a_root_first: assert property (mem_req_valid && first_q |->
    mem_req_addr == {root_q, idx, 3'h0}) else $error("bad root read");
  a_entry_align: assert property (mem_req_valid |->
    mem_req_addr[2:0] == 3'h0) else $error("unaligned entry read");
  a_mem_hold: assert property (mem_req_valid && !mem_req_ready
    |=> mem_req_valid && $stable(mem_req_addr))
    else $error("mem req moved");
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_pa) && $stable(rsp_fault))
    else $error("result moved");
  a_acc_tag: assert property (rsp_valid |-> rsp_acc == acc_q)
    else $error("wrong access type");
  a_offset_pass: assert property (rsp_valid && !rsp_fault |->
    rsp_pa[11:0] == va_q[11:0]) else $error("offset changed");
endmodule
bind pw_walker pw_walker_checker u_chk (.core_clk, .sys_rst, .root_ppn,
  .req_valid, .req_ready, .req_va, .req_mode, .req_acc, .rsp_valid,
  .rsp_ready, .rsp_pa, .rsp_fault, .rsp_acc, .mem_req_valid,
  .mem_req_ready, .mem_req_addr);

// >>> tb/test_pw_walker.sv
// Self-checking bench for the page walker.
`timescale 1ns/1ps
module test_pw_walker
  import pw_pkg::*;
;
  typedef struct {
    logic [63:0] va;
    pw_mode_type m;
    pw_acc_type a;
    logic f;
    logic [55:0] pa;
  } pw_row_type;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [43:0] root_ppn = 44'h1;
  logic req_valid = 1'b0;
  logic [63:0] req_va = '0;
  pw_mode_type req_mode = PW_MODE_39;
  pw_acc_type req_acc = PW_ACC_LOAD;
  logic rsp_ready = 1'b0;
  logic req_ready, rsp_valid, rsp_fault, mem_req_valid, mem_req_ready;
  logic mem_req_cas, mem_rsp_valid, mem_rsp_cas_ok;
  logic [55:0] rsp_pa, mem_req_addr;
  logic [63:0] mem_req_cmp, mem_req_wdata, mem_rsp_data;
  pw_acc_type rsp_acc;
  int miscompares = 0;
  int checks_done = 0;
  pw_row_type rows [13] = '{
    '{64'h203abc, PW_MODE_39, PW_ACC_LOAD, 0, 56'h55abc},
    '{64'h401234, PW_MODE_39, PW_ACC_FETCH, 0, 56'h201234},
    '{64'h800000, PW_MODE_39, PW_ACC_LOAD, 1, 0},
    '{64'ha00000, PW_MODE_39, PW_ACC_LOAD, 1, 0},
    '{64'hc00000, PW_MODE_39, PW_ACC_LOAD, 1, 0},
    '{64'he00000, PW_MODE_39, PW_ACC_LOAD, 1, 0},
    '{64'h1000000, PW_MODE_39, PW_ACC_LOAD, 1, 0},
    '{64'h1200000, PW_MODE_39, PW_ACC_STORE, 1, 0},
    '{64'h204000, PW_MODE_39, PW_ACC_LOAD, 1, 0},
    '{64'h80_1234_5678, PW_MODE_39, PW_ACC_FETCH, 1, 0},
    '{64'h80_1234_5678, PW_MODE_48, PW_ACC_LOAD, 0,
      56'h80_1234_5678},
    '{64'h1_0000_0000_0000, PW_MODE_48, PW_ACC_STORE, 1, 0},
    '{64'hffff_ffc0_0000_0abc, PW_MODE_39, PW_ACC_STORE, 0, 56'h4000_0abc}
  };
  always #12.5 core_clk = ~core_clk;
  pw_walker u_dut (.core_clk, .sys_rst, .root_ppn, .req_valid, .req_ready,
    .req_va, .req_mode, .req_acc, .rsp_valid, .rsp_ready, .rsp_pa,
    .rsp_fault, .rsp_acc, .mem_req_valid, .mem_req_ready, .mem_req_addr,
    .mem_req_cas, .mem_req_cmp, .mem_req_wdata, .mem_rsp_valid,
    .mem_rsp_data, .mem_rsp_cas_ok);
  pw_mem_model u_mem (.core_clk, .sys_rst, .mem_req_valid, .mem_req_ready,
    .mem_req_addr, .mem_req_cas, .mem_req_cmp, .mem_req_wdata,
    .mem_rsp_valid, .mem_rsp_data, .mem_rsp_cas_ok);
  function automatic logic [63:0] pte(logic [43:0] p, logic [9:0] f);
    return {10'h0, p, f};
  endfunction
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_for(input bit on_rsp);
    for (int n = 0; n < 300; n++) begin
      @(posedge core_clk);
      if ((on_rsp ? rsp_valid : req_ready) === 1'b1)
        return;
    end
    miscompares++;
    give_verdict();
  endtask
  task automatic xlate(input pw_row_type r);
    req_valid <= 1'b1;
    req_va <= r.va;
    req_mode <= r.m;
    req_acc <= r.a;
    wait_for(0);
    req_valid <= 1'b0;
    wait_for(1);
    rsp_ready <= 1'b1;
    @(posedge core_clk);
    check(rsp_fault, r.f);
    check(rsp_pa, r.pa);
    check(rsp_acc, r.a);
    rsp_ready <= 1'b0;
  endtask
  initial begin
    u_mem.mem[56'h1000] = pte(44'h2, 10'h001);
    u_mem.mem[56'h2008] = pte(44'h3, 10'h001);
    u_mem.mem[56'h3018] = pte(44'h55, 10'h0c7);
    u_mem.mem[56'h2010] = pte(44'h200, 10'h0c3);
    u_mem.mem[56'h2020] = pte(44'h201, 10'h0c3);
    u_mem.mem[56'h2028] = pte(44'h55, 10'h0c7) | 64'h8000_0000_0000_0000;
    u_mem.mem[56'h2030] = pte(44'h55, 10'h0c7) | 64'h2000_0000_0000_0000;
    u_mem.mem[56'h2038] = pte(44'h55, 10'h0c7) | 64'h0040_0000_0000_0000;
    u_mem.mem[56'h2040] = pte(44'h55, 10'h0c5);
    u_mem.mem[56'h3020] = pte(44'h3, 10'h001);
    u_mem.mem[56'h3028] = pte(44'h66, 10'h047);
    u_mem.mem[56'h1008] = pte(44'h800_0000, 10'h0c3);
    u_mem.mem[56'h1800] = pte(44'h4_0000, 10'h0c7);
    repeat (16) @(posedge core_clk);
    check(req_ready, 1);
    check(mem_req_valid, 0);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    for (int p = 0; p < 2; p++) begin
      u_mem.slow = p;
      foreach (rows[i])
        xlate(rows[i]);
    end
    u_mem.fail_cas = 1;
    xlate('{64'h205000, PW_MODE_39, PW_ACC_STORE, 0,
      56'h66000});
    check(u_mem.mem[56'h3028], pte(44'h66, 10'h0c7));
    check(u_mem.fail_cas, 0);
    req_valid <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b1;
    req_valid <= 1'b0;
    @(posedge core_clk);
    check(rsp_valid, 0);
    check(mem_req_valid, 0);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    xlate(rows[0]);
    give_verdict();
  end
endmodule
